// ---- verilog/ldo_cfg_pkg.sv ----
// Constants and carrier types for the three-regulator configuration bank.
// Assumes a serial-interface slave elsewhere delivers byte reads and writes.
package ldo_cfg_pkg;
	localparam logic [7:0] ADDR_LDO_A = 8'h40;
	localparam logic [7:0] ADDR_LDO_B = 8'h41;
	localparam logic [7:0] ADDR_LDO_C = 8'h42;
	localparam logic [7:0] ADDR_STATUS = 8'h43;
	localparam int VSEL_LSB = 0;
	localparam int VSEL_W = 5;
	localparam int EN_BIT = 5;
	localparam int WE_BIT = 1;
	localparam int DIS_LSB = 2;
	localparam int PG_LSB = 5;
	localparam logic [7:0] CTRL_WMASK = 8'h3f;
	localparam logic [7:0] STAT_WMASK = 8'h1e;
	localparam logic [4:0] VSEL_RST = 5'h00;
	localparam logic EN_RST = 1'b0;
	localparam logic WE_RST = 1'b0;
	localparam logic [2:0] DIS_RST = 3'h0;
	localparam int SOFT_START_US = 100;
	localparam int CLK_MHZ = 50;
	localparam int SOFT_START_CYC = SOFT_START_US * CLK_MHZ;

	typedef struct packed {
		logic enable;
		logic [4:0] voltage_select;
	} ldo_ctrl_t;

	typedef struct packed {
		logic write_exact;
		logic [2:0] discharge_enable;
	} ldo_stat_t;
endpackage

// ---- verilog/ldo_trio_config_registers.sv ----
// Register bank for three linear regulators: control bytes and status byte.
// Assumes byte-wide register access strobes from a serial slave on i_clk,
// and raw comparator levels from the analog regulators (asynchronous).
// Functional notes
// - Four 8-bit registers at addresses 40h to 43h.
// - Registers 40h-42h bits 4:0 hold each regulator's voltage select.
// - Bit 5 of each control register enables its regulator.
// - Bits 7:6 of 40h-42h and bit 0 of 43h are read-only.
// - Bit 1 of 43h is stored read/write; host writes its exact default.
// - 43h bits 2 and 3 are discharge enables for first and second regulator.
// - 43h bit 4 third discharge enable; bits 5-7 power-good flags.
// - Discharge active only while regulator disabled and its discharge enable bit set.
// - Power-good sets at high threshold, clears below hysteresis margin.
// - Soft-start delay after enable before power-good may assert.
// - Voltage code: upper two bits range, lower three step, 1.4 to 3.7 V.
// - Power-good bits read-only: 1 in regulation, 0 when output low.
`timescale 1ns/10ps
`default_nettype none

module ldo_trio_config_registers #(
	parameter int SOFT_START_CYCLES = ldo_cfg_pkg::SOFT_START_CYC,
	parameter logic [1:0] RO_HIGH_VALUE = 2'h0,
	parameter logic RO_STAT_BIT0 = 1'b0
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Register access from the serial slave
	input wire logic i_wr_strobe,
	input wire logic i_rd_strobe,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	// Analog comparators: above high threshold, above low threshold
	input wire logic [2:0] i_above_high,
	input wire logic [2:0] i_above_low,
	// Regulator controls
	output logic [2:0] o_ldo_on,
	output logic [14:0] o_voltage_select,
	output logic [2:0] o_discharge_on,
	output logic [2:0] o_power_good
);
	ldo_cfg_pkg::ldo_ctrl_t ctrl_r [3];
	ldo_cfg_pkg::ldo_stat_t stat_r;
	logic [2:0] hi_s1_r, hi_s2_r, lo_s1_r, lo_s2_r;
	logic [2:0] pg_r;
	logic [2:0] ss_done_r;
	logic [31:0] ss_cnt_r [3];
	logic [7:0] rdata_r;
	logic rvalid_r;
	logic [2:0] on_r, dis_r;
	logic [14:0] vsel_r;

	// Merge keeps read-only positions, takes writable ones from the host
	function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic [7:0] mask);
		merge = (old_v & ~mask) | (new_v & mask);
	endfunction

	// ============================================================
	// Address decode and readback
	// ============================================================
	wire logic [2:0] hit_ctrl;
	wire logic hit_stat;
	wire logic [7:0] ctrl_byte [3];
	wire logic [7:0] stat_byte;
	wire logic [7:0] rd_mux;
	assign hit_ctrl[0] = i_addr == ldo_cfg_pkg::ADDR_LDO_A;
	assign hit_ctrl[1] = i_addr == ldo_cfg_pkg::ADDR_LDO_B;
	assign hit_ctrl[2] = i_addr == ldo_cfg_pkg::ADDR_LDO_C;
	assign hit_stat = i_addr == ldo_cfg_pkg::ADDR_STATUS;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_byte
			assign ctrl_byte[g] = {RO_HIGH_VALUE, ctrl_r[g]};
		end
	endgenerate
	assign stat_byte = {pg_r, stat_r.discharge_enable, stat_r.write_exact, RO_STAT_BIT0};
	assign rd_mux = hit_ctrl[0] ? ctrl_byte[0] :
		hit_ctrl[1] ? ctrl_byte[1] :
		hit_ctrl[2] ? ctrl_byte[2] :
		hit_stat ? stat_byte : 8'h00;
	// Status fields are taken by bit position, so the packed order of the
	// struct cannot shuffle discharge and write-exact bits
	wire logic [7:0] stat_merged;
	assign stat_merged = merge(stat_byte, i_wdata, ldo_cfg_pkg::STAT_WMASK);

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= i_rd_strobe;
			if (i_rd_strobe) begin
				rdata_r <= rd_mux;
			end
		end
	end

	// ============================================================
	// Writable fields
	// ============================================================
	// Write strobe marks the end of the serial byte, so fields land whole
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int i = 0; i < 3; i++) begin
				ctrl_r[i] <= '{enable: ldo_cfg_pkg::EN_RST, voltage_select: ldo_cfg_pkg::VSEL_RST};
			end
			stat_r <= '{write_exact: ldo_cfg_pkg::WE_RST, discharge_enable: ldo_cfg_pkg::DIS_RST};
		end else if (i_wr_strobe) begin
			for (int i = 0; i < 3; i++) begin
				if (hit_ctrl[i]) begin
					ctrl_r[i] <= 6'(merge(ctrl_byte[i], i_wdata, ldo_cfg_pkg::CTRL_WMASK));
				end
			end
			if (hit_stat) begin
				stat_r <= '{write_exact: stat_merged[ldo_cfg_pkg::WE_BIT],
					discharge_enable: stat_merged[ldo_cfg_pkg::DIS_LSB +: 3]};
			end
		end
	end

	// ============================================================
	// Soft-start and power-good
	// ============================================================
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hi_s1_r <= 3'h0;
			hi_s2_r <= 3'h0;
			lo_s1_r <= 3'h0;
			lo_s2_r <= 3'h0;
		end else begin
			hi_s1_r <= i_above_high;
			hi_s2_r <= hi_s1_r;
			lo_s1_r <= i_above_low;
			lo_s2_r <= lo_s1_r;
		end
	end

	generate
		for (g = 0; g < 3; g++) begin : g_pg
			always_ff @(posedge i_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					ss_cnt_r[g] <= 32'h0;
					ss_done_r[g] <= 1'b0;
					pg_r[g] <= 1'b0;
				end else if (!ctrl_r[g].enable) begin
					ss_cnt_r[g] <= 32'h0;
					ss_done_r[g] <= 1'b0;
					pg_r[g] <= 1'b0;
				end else begin
					if (!ss_done_r[g]) begin
						ss_cnt_r[g] <= ss_cnt_r[g] + 32'h1;
						ss_done_r[g] <= ss_cnt_r[g] >= 32'(SOFT_START_CYCLES - 1);
					end
					// Hysteresis: set on high comparator, clear only below low one
					if (ss_done_r[g] && hi_s2_r[g]) begin
						pg_r[g] <= 1'b1;
					end else if (!lo_s2_r[g]) begin
						pg_r[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ============================================================
	// Regulator control outputs
	// ============================================================
	// Code is passed raw; the analog DAC maps range/step to 1.4..3.7 V
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			on_r <= 3'h0;
			dis_r <= 3'h0;
			vsel_r <= 15'h0000;
		end else begin
			for (int i = 0; i < 3; i++) begin
				on_r[i] <= ctrl_r[i].enable;
				dis_r[i] <= !ctrl_r[i].enable && stat_r.discharge_enable[i];
				vsel_r[i*5 +: 5] <= ctrl_r[i].voltage_select;
			end
		end
	end

	assign o_rdata = rdata_r;
	assign o_rvalid = rvalid_r;
	assign o_ldo_on = on_r;
	assign o_discharge_on = dis_r;
	assign o_voltage_select = vsel_r;
	assign o_power_good = pg_r;

	// ============================================================
	// Checks
	// ============================================================
	chk_discharge_off_when_on: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_ldo_on[0] |-> !o_discharge_on[0]) else $error("discharge while enabled");
	chk_pg_needs_enable: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(o_power_good[0]) |-> $past(ss_done_r[0] && ctrl_r[0].enable)) else $error("pg early");
	chk_pg_hold_hyst: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_power_good[1] && lo_s2_r[1] && ctrl_r[1].enable |=> o_power_good[1])
		else $error("pg dropped inside hysteresis");
	chk_ro_bits_kept: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_rd_strobe && hit_ctrl[2] |=> o_rdata[7:6] == RO_HIGH_VALUE) else $error("ro bits");
	chk_write_lands: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_wr_strobe && hit_ctrl[0] |=> ctrl_r[0] == 6'($past(i_wdata) & ldo_cfg_pkg::CTRL_WMASK) ##1
		o_ldo_on[0] == ctrl_r[0].enable) else $error("write not applied");
	chk_stat_write: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_wr_strobe && hit_stat |=> stat_r.discharge_enable == $past(i_wdata[4:2]))
		else $error("discharge bits not stored");
	chk_we_bit: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_wr_strobe && hit_stat |=> stat_r.write_exact == $past(i_wdata[1]))
		else $error("write-exact bit");
	chk_read_pg: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_rd_strobe && hit_stat |=> o_rdata[7:5] == $past(pg_r)) else $error("pg readback");
	chk_unmapped_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_rd_strobe && !hit_stat && hit_ctrl == 3'h0 |=> o_rdata == 8'h00 && o_rvalid)
		else $error("unmapped read");
endmodule

`default_nettype wire

// ---- test/ldo_analog_model.sv ----
// Behavioural analog side: threshold comparators of three regulators.
// Assumes the register bank's control outputs on the same clock.
`timescale 1ns/10ps
`default_nettype none
module ldo_analog_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Controls; sag 0 none, 1 between thresholds, 2 below both
	input wire logic [2:0] i_ldo_on,
	input wire logic [1:0] i_sag,
	// Comparator levels
	output logic [2:0] o_above_high,
	output logic [2:0] o_above_low
);
	logic [2:0] ramp_r;
	logic [2:0] up_r;
	// Output climbs over two cycles, collapses one cycle after off
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ramp_r <= 3'h0;
			up_r <= 3'h0;
		end else begin
			ramp_r <= i_ldo_on;
			up_r <= ramp_r & i_ldo_on;
		end
	end
	assign o_above_high = (i_sag == 2'h0) ? up_r : 3'h0;
	assign o_above_low = (i_sag == 2'h2) ? 3'h0 : up_r;
endmodule
`default_nettype wire

// ---- test/ldo_trio_config_registers_bench.sv ----
// Self-checking bench for the regulator register bank.
// Assumes byte strobes as a serial slave would give them.
`timescale 1ns/10ps
`default_nettype none
module ldo_trio_config_registers_bench;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [1:0] sag = 2'h0;
	logic [7:0] rdata;
	logic rvalid;
	logic [2:0] hi, lo, on, dis, pg;
	logic [14:0] vsel;
	int failures = 0;
	int comparisons = 0;
	always #10 clk = ~clk;
	// Short soft-start keeps the run brief
	ldo_trio_config_registers #(.SOFT_START_CYCLES(8)) ldo_trio_config_registers_i (
		.i_clk(clk), .i_reset_n(reset_n), .i_wr_strobe(wr_s), .i_rd_strobe(rd_s),
		.i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
		.i_above_high(hi), .i_above_low(lo), .o_ldo_on(on), .o_voltage_select(vsel),
		.o_discharge_on(dis), .o_power_good(pg));
	ldo_analog_model ldo_analog_model_i (.i_clk(clk), .i_reset_n(reset_n),
		.i_ldo_on(on), .i_sag(sag), .o_above_high(hi), .o_above_low(lo));
	task automatic conclude;
		$display("counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk({7'h00, rvalid, rdata}, {8'h01, e});
	endtask
	task automatic wait_pg(input logic [2:0] e);
		int n;
		n = 0;
		#1;
		while (pg !== e && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk({13'h0000, pg}, {13'h0000, e});
		if (pg !== e) begin
			conclude();
		end
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		rd(8'h40, 8'h00);
		for (int i = 0; i < 3; i++) begin
			wr(8'h40 + 8'(i), 8'hca + 8'(i));
			rd(8'h40 + 8'(i), 8'h0a + 8'(i));
		end
		chk({1'b0, vsel}, {1'b0, 5'h0c, 5'h0b, 5'h0a});
		wr(8'h43, 8'hfd);
		@(posedge clk);
		#1;
		chk({13'h0000, dis}, 16'h0007);
		rd(8'h43, 8'h1c);
		$display("test registers done");
		for (int i = 0; i < 3; i++) begin
			wr(8'h40 + 8'(i), 8'h2a + 8'(i));
		end
		@(posedge clk);
		#1;
		chk({10'h000, on, dis}, 16'h0038);
		chk({13'h0000, pg}, 16'h0000);
		wait_pg(3'h7);
		rd(8'h43, 8'hfc);
		sag <= 2'h1;
		repeat (6) @(posedge clk);
		#1;
		chk({13'h0000, pg}, 16'h0007);
		sag <= 2'h2;
		wait_pg(3'h0);
		sag <= 2'h0;
		wait_pg(3'h7);
		wr(8'h41, 8'h0b);
		wait_pg(3'h5);
		chk({13'h0000, dis}, 16'h0002);
		$display("test enables done");
		wr(8'h44, 8'hff);
		rd(8'h44, 8'h00);
		rd(8'h40, 8'h2a);
		$display("test unmapped done");
		conclude();
	end
endmodule
`default_nettype wire
